// File: logic/nvmc_pkg.sv
// constants and types of the nvm control bits block
//
// Summary of operation
// - erase trigger bit 5 starts erase cycle
// - hardware clears erase trigger when erase ends
// - erase trigger ignored unless erase enable set
// - mode bit 4: zero byte, one page
// - page mode erases; byte mode only writes/reads
// - write enable bit 3 required for writes
// - hardware clears write enable after write ends
// - write trigger bit 2 starts write cycle
// - read enable bit 1 required for reads
// - read trigger bit 0 starts read cycle
// - hardware clears read trigger after read ends
// - read trigger ignored unless read enable set
// - erase enable bit 6, cleared after erase
// - page operation covers at most 16 bytes
package nvmc_pkg;

  // ----------------------------------------
  // register map and field positions
  // ----------------------------------------
  localparam int unsigned NVMC_AW       = 2;
  localparam int unsigned NVMC_DW       = 8;
  localparam logic [1:0]  NVMC_OFS_CTRL = 2'h0;
  localparam logic [1:0]  NVMC_OFS_STAT = 2'h1;
  localparam logic [1:0]  NVMC_OFS_MASK = 2'h2;
  localparam int unsigned NVMC_B_RD_TRG = 0;
  localparam int unsigned NVMC_B_RD_EN  = 1;
  localparam int unsigned NVMC_B_WR_TRG = 2;
  localparam int unsigned NVMC_B_WR_EN  = 3;
  localparam int unsigned NVMC_B_MODE   = 4;
  localparam int unsigned NVMC_B_ER_TRG = 5;
  localparam int unsigned NVMC_B_ER_EN  = 6;
  localparam logic [7:0]  NVMC_CTRL_RST = 8'h00;

  // ----------------------------------------
  // event bits, shared by status and mask
  // ----------------------------------------
  localparam int unsigned NVMC_EV_W     = 4;
  localparam int unsigned NVMC_EV_ER    = 0;
  localparam int unsigned NVMC_EV_WR    = 1;
  localparam int unsigned NVMC_EV_RD    = 2;
  localparam int unsigned NVMC_EV_REF   = 3;
  localparam logic [3:0]  NVMC_MASK_RST = 4'h0;

  // ----------------------------------------
  // cycle lengths in clocks, page size
  // ----------------------------------------
  localparam int unsigned NVMC_TW       = 16;
  localparam logic [15:0] NVMC_ER_CYC   = 16'h0064;
  localparam logic [15:0] NVMC_WR_CYC   = 16'h0032;
  localparam logic [15:0] NVMC_RD_CYC   = 16'h0004;
  localparam int unsigned NVMC_PAGE_MAX = 16;

  typedef enum logic [1:0] {
    NVMC_ST_IDLE  = 2'b00,
    NVMC_ST_ERASE = 2'b01,
    NVMC_ST_WRITE = 2'b10,
    NVMC_ST_READ  = 2'b11
  } nvmc_state_t;

endpackage

// File: logic/nvmc_cycle_timer.sv
// down counter that times one nonvolatile cycle
`timescale 1ns/100ps
module nvmc_cycle_timer
  import nvmc_pkg::*;
#(
  parameter int unsigned TW = NVMC_TW
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_clk_en,
  input  wire logic          i_start,
  input  wire logic [TW-1:0] i_len,
  output logic               o_done
);

  // the last-tick compare needs at least two counter bits
  if (TW < 2) begin : g_bad_tw
    $error("timer width too small");
  end

  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic          done_r;
  logic          done_nxt;

  // ----------------------------------------
  // count down, pulse done at the last tick
  // ----------------------------------------
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (i_start) begin
      cnt_nxt = i_len;
    end else if (cnt_r != '0) begin
      cnt_nxt  = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(TW-1){1'b0}}, 1'b1});
    end
  end

  // state frozen while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (i_clk_en) begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;

endmodule

// File: logic/nvmc_irq.sv
// sticky event status, mask and level interrupt
`timescale 1ns/100ps
module nvmc_irq
  import nvmc_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_clk_en,
  input  wire logic [NVMC_EV_W-1:0] i_event,
  input  wire logic                 i_stat_rd,
  input  wire logic                 i_mask_we,
  input  wire logic [NVMC_EV_W-1:0] i_mask_data,
  output logic      [NVMC_EV_W-1:0] o_status,
  output logic      [NVMC_EV_W-1:0] o_mask,
  output logic                      o_irq
);

  logic [NVMC_EV_W-1:0] stat_r;
  logic [NVMC_EV_W-1:0] stat_nxt;
  logic [NVMC_EV_W-1:0] mask_r;
  logic [NVMC_EV_W-1:0] mask_nxt;
  logic                 irq_r;
  logic                 irq_nxt;

  // ----------------------------------------
  // read clears, a new event in the same cycle survives
  // ----------------------------------------
  always_comb begin
    stat_nxt = (i_stat_rd ? '0 : stat_r) | i_event;
    mask_nxt = i_mask_we ? i_mask_data : mask_r;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_r <= '0;
      mask_r <= NVMC_MASK_RST;
      irq_r  <= 1'b0;
    end else if (i_clk_en) begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign o_status = stat_r;
  assign o_mask   = mask_r;
  assign o_irq    = irq_r;

endmodule

// File: logic/nvmc_ctrl.sv
// nvm control register, cycle sequencer and register port
`timescale 1ns/100ps
module nvmc_ctrl
  import nvmc_pkg::*;
#(
  parameter logic [15:0] ER_CYC     = NVMC_ER_CYC,
  parameter logic [15:0] WR_CYC     = NVMC_WR_CYC,
  parameter logic [15:0] RD_CYC     = NVMC_RD_CYC,
  parameter int unsigned PAGE_BYTES = NVMC_PAGE_MAX
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  input  wire logic [NVMC_AW-1:0] i_addr,
  input  wire logic [NVMC_DW-1:0] i_wr_data,
  input  wire logic               i_wr_stb,
  input  wire logic               i_rd_stb,
  output logic      [NVMC_DW-1:0] o_rd_data,
  output logic                    o_irq,
  output logic                    o_op_start,
  output logic      [1:0]         o_op_kind,
  output logic                    o_page_mode,
  output logic      [3:0]         o_op_last,
  output logic                    o_busy
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (PAGE_BYTES < 1 || PAGE_BYTES > NVMC_PAGE_MAX) begin : g_bad_page
    $error("page size out of range");
  end
  if (ER_CYC == 16'h0000 || WR_CYC == 16'h0000 || RD_CYC == 16'h0000) begin : g_bad_cyc
    $error("cycle lengths must be nonzero");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  nvmc_state_t          state_r;
  nvmc_state_t          state_nxt;
  logic [7:0]           ctrl_r;
  logic [7:0]           ctrl_nxt;
  logic [7:0]           rd_data_r;
  logic [7:0]           rd_data_nxt;
  logic                 start_r;
  logic                 start_nxt;
  logic [1:0]           kind_r;
  logic [1:0]           kind_nxt;
  logic                 page_r;
  logic                 page_nxt;
  logic [3:0]           last_r;
  logic [3:0]           last_nxt;
  logic                 busy_r;
  logic                 busy_nxt;
  logic                 go;
  logic [15:0]          go_len;
  logic                 tmr_done;
  logic [NVMC_EV_W-1:0] events;
  logic [NVMC_EV_W-1:0] stat;
  logic [NVMC_EV_W-1:0] mask;
  logic                 irq;
  logic                 ctrl_we;
  logic                 req_er;
  logic                 req_wr;
  logic                 req_rd;
  logic                 idle;

  // one decode shared by write and read paths
  function automatic logic hit(input logic [NVMC_AW-1:0] a, input logic [NVMC_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // strobe decode
  // ----------------------------------------
  assign ctrl_we = i_wr_stb && hit(i_addr, NVMC_OFS_CTRL);
  assign req_er  = ctrl_we && i_wr_data[NVMC_B_ER_TRG];
  assign req_wr  = ctrl_we && i_wr_data[NVMC_B_WR_TRG];
  assign req_rd  = ctrl_we && i_wr_data[NVMC_B_RD_TRG];
  assign idle    = (state_r == NVMC_ST_IDLE);

  // ----------------------------------------
  // control register and cycle sequencer
  // ----------------------------------------
  // triggers are hardware owned once set: a written zero cannot abort
  // a cycle in flight, since the array timer has no abort path
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt  = ctrl_r;
    go        = 1'b0;
    go_len    = RD_CYC;
    kind_nxt  = kind_r;
    page_nxt  = page_r;
    events    = '0;
    if (ctrl_we) begin
      ctrl_nxt[NVMC_B_RD_EN] = i_wr_data[NVMC_B_RD_EN];
      ctrl_nxt[NVMC_B_WR_EN] = i_wr_data[NVMC_B_WR_EN];
      ctrl_nxt[NVMC_B_MODE]  = i_wr_data[NVMC_B_MODE];
      ctrl_nxt[NVMC_B_ER_EN] = i_wr_data[NVMC_B_ER_EN];
    end
    // enables are judged as they stood before this write
    if (idle) begin
      if (req_wr) begin
        // write wins if software breaks the one-trigger habit
        if (ctrl_r[NVMC_B_WR_EN]) begin
          go                      = 1'b1;
          go_len                  = WR_CYC;
          state_nxt               = NVMC_ST_WRITE;
          ctrl_nxt[NVMC_B_WR_TRG] = 1'b1;
        end else begin
          events[NVMC_EV_REF]     = 1'b1;
        end
      end else if (req_rd) begin
        if (ctrl_r[NVMC_B_RD_EN]) begin
          go                      = 1'b1;
          go_len                  = RD_CYC;
          state_nxt               = NVMC_ST_READ;
          ctrl_nxt[NVMC_B_RD_TRG] = 1'b1;
        end else begin
          events[NVMC_EV_REF]     = 1'b1;
        end
      end else if (req_er) begin
        // erase exists only in page form
        if (ctrl_r[NVMC_B_ER_EN] && i_wr_data[NVMC_B_MODE]) begin
          go                      = 1'b1;
          go_len                  = ER_CYC;
          state_nxt               = NVMC_ST_ERASE;
          ctrl_nxt[NVMC_B_ER_TRG] = 1'b1;
        end else begin
          events[NVMC_EV_REF]     = 1'b1;
        end
      end
      if (go) begin
        kind_nxt = state_nxt;
        page_nxt = i_wr_data[NVMC_B_MODE];
      end
    end else if (req_er || req_wr || req_rd) begin
      // a second trigger while busy is dropped and flagged
      events[NVMC_EV_REF] = 1'b1;
    end
    // cycle end: hardware clear overrides any same-cycle write
    if (tmr_done) begin
      state_nxt = NVMC_ST_IDLE;
      case (state_r)
        NVMC_ST_ERASE: begin
          ctrl_nxt[NVMC_B_ER_TRG] = 1'b0;
          ctrl_nxt[NVMC_B_ER_EN]  = 1'b0;
          events[NVMC_EV_ER]      = 1'b1;
        end
        NVMC_ST_WRITE: begin
          ctrl_nxt[NVMC_B_WR_TRG] = 1'b0;
          ctrl_nxt[NVMC_B_WR_EN]  = 1'b0;
          events[NVMC_EV_WR]      = 1'b1;
        end
        NVMC_ST_READ: begin
          ctrl_nxt[NVMC_B_RD_TRG] = 1'b0;
          events[NVMC_EV_RD]      = 1'b1;
        end
        default: begin
          state_nxt = NVMC_ST_IDLE;
        end
      endcase
    end
    ctrl_nxt[7] = 1'b0;
  end

  // ----------------------------------------
  // array-side outputs and read port
  // ----------------------------------------
  always_comb begin
    start_nxt   = go;
    busy_nxt    = (state_nxt != NVMC_ST_IDLE);
    // page holds up to PAGE_BYTES, byte mode one
    last_nxt    = last_r;
    if (go) begin
      last_nxt  = page_nxt ? 4'(PAGE_BYTES - 1) : 4'h0;
    end
    rd_data_nxt = 8'h00;
    if (i_rd_stb) begin
      if (hit(i_addr, NVMC_OFS_CTRL)) begin
        rd_data_nxt = ctrl_r;
      end else if (hit(i_addr, NVMC_OFS_STAT)) begin
        rd_data_nxt = {4'h0, stat};
      end else if (hit(i_addr, NVMC_OFS_MASK)) begin
        rd_data_nxt = {4'h0, mask};
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
  end

  // all state held while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r   <= NVMC_ST_IDLE;
      ctrl_r    <= NVMC_CTRL_RST;
      rd_data_r <= 8'h00;
      start_r   <= 1'b0;
      kind_r    <= NVMC_ST_IDLE;
      page_r    <= 1'b0;
      last_r    <= 4'h0;
      busy_r    <= 1'b0;
    end else if (i_clk_en) begin
      state_r   <= state_nxt;
      ctrl_r    <= ctrl_nxt;
      rd_data_r <= rd_data_nxt;
      start_r   <= start_nxt;
      kind_r    <= kind_nxt;
      page_r    <= page_nxt;
      last_r    <= last_nxt;
      busy_r    <= busy_nxt;
    end
  end

  assign o_rd_data   = rd_data_r;
  assign o_op_start  = start_r;
  assign o_op_kind   = kind_r;
  assign o_page_mode = page_r;
  assign o_op_last   = last_r;
  assign o_busy      = busy_r;
  assign o_irq       = irq;

  // ----------------------------------------
  // cycle timer and interrupt logic
  // ----------------------------------------
  nvmc_cycle_timer #(
    .TW (NVMC_TW)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_start   (go),
    .i_len     (go_len),
    .o_done    (tmr_done)
  );

  nvmc_irq u_irq (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_clk_en    (i_clk_en),
    .i_event     (events),
    .i_stat_rd   (i_rd_stb && hit(i_addr, NVMC_OFS_STAT)),
    .i_mask_we   (i_wr_stb && hit(i_addr, NVMC_OFS_MASK)),
    .i_mask_data (i_wr_data[NVMC_EV_W-1:0]),
    .o_status    (stat),
    .o_mask      (mask),
    .o_irq       (irq)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // clocks spent in the running cycle, read only by the length checks;
  // it counts under the same enable as the timer, so a freeze cannot skew it
  logic [15:0] run_cnt_r;
  logic [15:0] run_cnt_nxt;

  // restart at each accepted trigger, count while not idle
  always_comb begin
    run_cnt_nxt = run_cnt_r;
    if (go) begin
      run_cnt_nxt = 16'h0000;
    end else if (!idle) begin
      run_cnt_nxt = run_cnt_r + 16'h0001;
    end
  end

  // held like every other register while the enable is low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_cnt_r <= 16'h0000;
    end else if (i_clk_en) begin
      run_cnt_r <= run_cnt_nxt;
    end
  end

  sequence s_wr_go;
    i_clk_en && idle && req_wr && ctrl_r[NVMC_B_WR_EN];
  endsequence
  sequence s_wr_busy;
    ctrl_r[NVMC_B_WR_TRG] && state_r == NVMC_ST_WRITE;
  endsequence
  sequence s_rd_go;
    i_clk_en && idle && req_rd && !req_wr && ctrl_r[NVMC_B_RD_EN];
  endsequence
  sequence s_rd_busy;
    ctrl_r[NVMC_B_RD_TRG] && state_r == NVMC_ST_READ;
  endsequence
  sequence s_er_go;
    i_clk_en && idle && req_er && !req_wr && !req_rd && ctrl_r[NVMC_B_ER_EN] && i_wr_data[NVMC_B_MODE];
  endsequence
  sequence s_er_busy;
    ctrl_r[NVMC_B_ER_TRG] && state_r == NVMC_ST_ERASE;
  endsequence

  AST_ER_NEEDS_EN: assert property (
    (i_clk_en && idle && req_er && !ctrl_r[NVMC_B_ER_EN]) |=> (!ctrl_r[NVMC_B_ER_TRG] && state_r != NVMC_ST_ERASE))
    else $error("erase started without erase enable");
  AST_WR_NEEDS_EN: assert property (
    (i_clk_en && idle && req_wr && !ctrl_r[NVMC_B_WR_EN]) |=> (!ctrl_r[NVMC_B_WR_TRG] && idle))
    else $error("write started without write enable");
  AST_RD_NEEDS_EN: assert property (
    (i_clk_en && idle && req_rd && !req_wr && !ctrl_r[NVMC_B_RD_EN]) |=> (!ctrl_r[NVMC_B_RD_TRG] && idle))
    else $error("read started without read enable");
  AST_BYTE_NO_ERASE: assert property (
    (i_clk_en && idle && req_er && !i_wr_data[NVMC_B_MODE]) |=> state_r != NVMC_ST_ERASE)
    else $error("erase accepted in byte mode");
  AST_WR_SEQ: assert property (
    s_wr_go |=> s_wr_busy ##0 (o_op_start && o_op_kind == NVMC_ST_WRITE))
    else $error("write trigger did not start a write cycle");
  AST_ER_END: assert property (
    (i_clk_en && tmr_done && state_r == NVMC_ST_ERASE) |=> (!ctrl_r[NVMC_B_ER_TRG] && !ctrl_r[NVMC_B_ER_EN] && idle))
    else $error("erase end left trigger or enable set");
  AST_WR_END: assert property (
    (i_clk_en && tmr_done && state_r == NVMC_ST_WRITE) |=> (!ctrl_r[NVMC_B_WR_TRG] && !ctrl_r[NVMC_B_WR_EN]))
    else $error("write end left trigger or enable set");
  AST_RD_END: assert property (
    (i_clk_en && tmr_done && state_r == NVMC_ST_READ) |=> (!ctrl_r[NVMC_B_RD_TRG] && !o_busy))
    else $error("read end left trigger set");
  AST_PAGE_LEN: assert property (
    (o_op_start && o_page_mode) |-> o_op_last == 4'(PAGE_BYTES - 1))
    else $error("page length wrong");
  AST_RD_SEQ: assert property (
    s_rd_go |=> s_rd_busy ##0 (o_op_start && o_op_kind == NVMC_ST_READ))
    else $error("read trigger did not start a read cycle");
  AST_ER_SEQ: assert property (
    s_er_go |=> s_er_busy ##0 (o_op_start && o_op_kind == NVMC_ST_ERASE && o_page_mode))
    else $error("erase trigger did not start a page erase");
  AST_MODE_LATCH: assert property (
    (i_clk_en && go) |=> o_page_mode == $past(i_wr_data[NVMC_B_MODE]))
    else $error("mode not latched at cycle start");
  AST_BYTE_LAST: assert property (
    (o_op_start && !o_page_mode) |-> o_op_last == 4'h0)
    else $error("byte operation with a page length");
  AST_RD_EN_WRITE: assert property (
    (i_clk_en && ctrl_we) |=> ctrl_r[NVMC_B_RD_EN] == $past(i_wr_data[NVMC_B_RD_EN]))
    else $error("read enable did not follow the write");
  AST_START_PULSE: assert property (
    (i_clk_en && o_op_start) |=> !o_op_start)
    else $error("start pulse longer than one cycle");
  AST_TRG_BUSY: assert property (
    (ctrl_r[NVMC_B_ER_TRG] || ctrl_r[NVMC_B_WR_TRG] || ctrl_r[NVMC_B_RD_TRG]) == !idle)
    else $error("trigger bit and running cycle disagree");
  AST_ER_LEN: assert property (
    (i_clk_en && tmr_done && state_r == NVMC_ST_ERASE) |-> run_cnt_r == ER_CYC)
    else $error("erase cycle length wrong");
  AST_WR_LEN: assert property (
    (i_clk_en && tmr_done && state_r == NVMC_ST_WRITE) |-> run_cnt_r == WR_CYC)
    else $error("write cycle length wrong");
  AST_RD_LEN: assert property (
    (i_clk_en && tmr_done && state_r == NVMC_ST_READ) |-> run_cnt_r == RD_CYC)
    else $error("read cycle length wrong");

endmodule

// File: verif/nvmc_ctrl_tb.sv
// self-checking testbench of the nvm control bits block
`timescale 1ns/100ps
module nvmc_ctrl_tb
  import nvmc_pkg::*;
;

  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  logic               i_ref_clk;
  logic               i_rst_n;
  logic               i_clk_en;
  logic [NVMC_AW-1:0] i_addr;
  logic [NVMC_DW-1:0] i_wr_data;
  logic               i_wr_stb;
  logic               i_rd_stb;
  logic [NVMC_DW-1:0] o_rd_data;
  logic               o_irq;
  logic               o_op_start;
  logic [1:0]         o_op_kind;
  logic               o_page_mode;
  logic [3:0]         o_op_last;
  logic               o_busy;
  int                 mismatches;
  int                 comparisons;
  int                 seed;

  // short cycle lengths keep the run brief
  nvmc_ctrl #(
    .ER_CYC     (16'h0004),
    .WR_CYC     (16'h0003),
    .RD_CYC     (16'h0002),
    .PAGE_BYTES (16)
  ) i_dut (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_clk_en    (i_clk_en),
    .i_addr      (i_addr),
    .i_wr_data   (i_wr_data),
    .i_wr_stb    (i_wr_stb),
    .i_rd_stb    (i_rd_stb),
    .o_rd_data   (o_rd_data),
    .o_irq       (o_irq),
    .o_op_start  (o_op_start),
    .o_op_kind   (o_op_kind),
    .o_page_mode (o_page_mode),
    .o_op_last   (o_op_last),
    .o_busy      (o_busy)
  );

  // 25 MHz reference clock
  initial i_ref_clk = 1'b0;
  always #20 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0s expected %02h seen %02h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0s expected %b seen %b", what, exp, got);
    end
  endtask

  // a wait edge before raising keeps one driver per time step
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_stb  <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_stb  <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_addr   <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    @(negedge i_ref_clk);
    chk8(what, exp, o_rd_data);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // bits that survive a control write: enables and mode, never bit 7 or a trigger
  function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
    return d & 8'h5A;
  endfunction

  // enable write, trigger write, then follow the cycle to its end
  task automatic run_op(input string name, input logic [7:0] en, input logic [7:0] trg,
                        input logic [1:0] kind, input logic [7:0] ctl, input logic [7:0] st);
    int   n;
    logic seen;
    seen = 1'b0;
    wr(NVMC_OFS_CTRL, en);
    wr(NVMC_OFS_CTRL, trg);
    for (n = 0; n < 8 && !seen; n++) begin
      @(negedge i_ref_clk);
      seen = (o_op_start === 1'b1);
    end
    chk1("cycle started", kind != 2'd0, seen);
    if (seen) begin
      chk8("op kind", {6'h00, kind}, {6'h00, o_op_kind});
      chk1("page mode", trg[NVMC_B_MODE], o_page_mode);
      chk8("last index", trg[NVMC_B_MODE] ? 8'h0F : 8'h00, {4'h0, o_op_last});
      chk1("busy", 1'b1, o_busy);
    end
    for (n = 0; n < 400 && o_busy !== 1'b0; n++) begin
      @(negedge i_ref_clk);
    end
    chk1("busy ended", 1'b0, o_busy);
    rd_chk("control after", NVMC_OFS_CTRL, ctl);
    chk1("irq raised", 1'b1, o_irq);
    rd_chk("status", NVMC_OFS_STAT, st);
    rd_chk("status cleared", NVMC_OFS_STAT, 8'h00);
    chk1("irq dropped", 1'b0, o_irq);
    $display("test %0s done", name);
  endtask

  // ----------------------------------------
  // watchdog, far above the expected run
  // ----------------------------------------
  initial begin
    repeat (6000) @(posedge i_ref_clk);
    mismatches++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int r;
    seed        = 73;
    mismatches  = 0;
    comparisons = 0;
    i_rst_n     = 1'b0;
    i_clk_en    = 1'b1;
    i_addr      = '0;
    i_wr_data   = '0;
    i_wr_stb    = 1'b0;
    i_rd_stb    = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(negedge i_ref_clk);
    chk1("busy at reset", 1'b0, o_busy);
    chk1("irq at reset", 1'b0, o_irq);
    rd_chk("control reset", NVMC_OFS_CTRL, NVMC_CTRL_RST);
    rd_chk("status reset", NVMC_OFS_STAT, 8'h00);
    rd_chk("mask reset", NVMC_OFS_MASK, {4'h0, NVMC_MASK_RST});
    $display("test reset done");

    // all events unmasked so every event shows on the interrupt
    wr(NVMC_OFS_MASK, 8'h0F);
    run_op("write no enable", 8'h00, 8'h04, 2'd0, 8'h00, 8'h08);
    run_op("byte write", 8'h08, 8'h0C, 2'd2, 8'h00, 8'h02);
    run_op("page write", 8'h18, 8'h1C, 2'd2, 8'h10, 8'h02);
    run_op("read no enable", 8'h00, 8'h01, 2'd0, 8'h00, 8'h08);
    run_op("byte read", 8'h02, 8'h03, 2'd3, 8'h02, 8'h04);
    run_op("page read", 8'h12, 8'h13, 2'd3, 8'h12, 8'h04);
    run_op("erase no enable", 8'h10, 8'h30, 2'd0, 8'h10, 8'h08);
    run_op("erase byte mode", 8'h40, 8'h60, 2'd0, 8'h40, 8'h08);
    run_op("page erase", 8'h50, 8'h70, 2'd1, 8'h10, 8'h01);

    // random mask and control values, unmapped place among them
    for (int k = 0; k < 24; k++) begin
      r = $random(seed);
      wr(NVMC_OFS_MASK, r[7:0]);
      rd_chk("mask", NVMC_OFS_MASK, {4'h0, r[3:0]});
      wr(NVMC_OFS_CTRL, r[15:8] & 8'hDA);
      rd_chk("control hold", NVMC_OFS_CTRL, exp_ctrl(r[15:8]));
      wr(2'h3, r[23:16]);
      rd_chk("unmapped", 2'h3, 8'h00);
    end
    $display("test random registers done");

    // a masked event keeps the interrupt low but still shows in status
    wr(NVMC_OFS_MASK, 8'h00);
    wr(NVMC_OFS_CTRL, 8'h00);
    wr(NVMC_OFS_CTRL, 8'h04);
    repeat (3) @(negedge i_ref_clk);
    chk1("masked irq", 1'b0, o_irq);
    rd_chk("masked status", NVMC_OFS_STAT, 8'h08);
    $display("test masked event done");

    // a control write while the clock enable is low must not land
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    wr(NVMC_OFS_CTRL, 8'h5A);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    rd_chk("frozen write", NVMC_OFS_CTRL, 8'h00);
    $display("test clock enable done");
    summarize();
  end

endmodule
